// file: core/wdtu_pkg.sv
// Package: register map, command keys, timing and carrier types of the watchdog timer unit
package wdtu_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] WDTC_IDX    = 12'h0FF;
  localparam logic [11:0] WDTC_ADDR   = WDTC_IDX << 2;   // Four times the index
  localparam logic [11:0] ISTAT_ADDR  = 12'h400;
  localparam logic [11:0] IMASK_ADDR  = 12'h404;

  // ----------------------------------------------------------------
  // Control register fields and keys
  // ----------------------------------------------------------------
  localparam int          CMD_BIT     = 7;
  localparam int          STAT_BIT    = 4;
  localparam int          INTV_W      = 3;
  localparam logic [2:0]  INTV_RST    = 3'h7;
  localparam logic [7:0]  KEY_ENABLE  = 8'hA5;
  localparam logic [7:0]  KEY_DIS1    = 8'hDE;
  localparam logic [7:0]  KEY_DIS2    = 8'hAD;
  localparam logic [7:0]  KEY_LOCK    = 8'hFF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CNT_W       = 21;
  localparam int          INTV_SHIFT  = 6;          // Four to the third, as a power of two
  localparam logic [2:0]  DIS_WIN_CYC = 3'h4;

  // ----------------------------------------------------------------
  // Interrupt events and bus response codes
  // ----------------------------------------------------------------
  localparam int          EV_W        = 4;
  localparam int          EV_EXPIRE   = 0;
  localparam int          EV_DISABLE  = 1;
  localparam int          EV_LOCK     = 2;
  localparam int          EV_REJECT   = 3;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } wdtu_wr_t;

  typedef struct packed {
    logic [31:0] data;
    logic        ok;
  } wdtu_rd_t;

endpackage : wdtu_pkg

// file: core/wdtu_axil.sv
// AXI4-Lite slave front end of the watchdog timer unit
module wdtu_axil (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [11:0]       awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [11:0]       araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic                   wr_en,
  output wdtu_pkg::wdtu_wr_t     wr,
  input  wire logic              wr_ok,
  output logic                   rd_en,
  output logic [11:0]            rd_addr,
  input  wire wdtu_pkg::wdtu_rd_t rd
);

  logic        aw_full;
  logic        w_full;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        aw_take;
  logic        w_take;
  logic        next_aw_full;
  logic        next_w_full;
  logic        next_bvalid;
  logic        next_rvalid;

  // ----------------------------------------------------------------
  // Write path: address and data taken in either order
  // ----------------------------------------------------------------
  assign aw_take      = awvalid && awready;
  assign w_take       = wvalid && wready;
  assign wr_en        = (aw_full || aw_take) && (w_full || w_take);
  assign wr.addr      = aw_full ? aw_addr : awaddr;
  assign wr.data      = w_full ? w_data : wdata;
  assign wr.strb      = w_full ? w_strb : wstrb;
  assign next_aw_full = (aw_full || aw_take) && !wr_en;
  assign next_w_full  = (w_full || w_take) && !wr_en;
  assign next_bvalid  = wr_en || (bvalid && !bready);

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= 12'h000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      if (aw_take) begin
        aw_addr <= awaddr;
      end
      if (w_take) begin
        w_data <= wdata;
        w_strb <= wstrb;
      end
    end
  end

  // Ready drops while a response waits, so one write at most is in flight
  always_ff @(posedge clk) begin
    if (rst) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= wdtu_pkg::RESP_OKAY;
    end else begin
      awready <= !next_aw_full && !next_bvalid;
      wready  <= !next_w_full && !next_bvalid;
      bvalid  <= next_bvalid;
      if (wr_en) begin
        bresp <= wr_ok ? wdtu_pkg::RESP_OKAY : wdtu_pkg::RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign rd_en       = arvalid && arready;
  assign rd_addr     = araddr;
  assign next_rvalid = rd_en || (rvalid && !rready);

  always_ff @(posedge clk) begin
    if (rst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= wdtu_pkg::RESP_OKAY;
    end else begin
      arready <= !next_rvalid;
      rvalid  <= next_rvalid;
      if (rd_en) begin
        rdata <= rd.data;
        rresp <= rd.ok ? wdtu_pkg::RESP_OKAY : wdtu_pkg::RESP_SLVERR;
      end
    end
  end

endmodule : wdtu_axil

// file: core/wdtu_top.sv
// Watchdog timer unit: key-driven control register, timeout counter and interrupt status
//
// Our own choice: the AXI4-Lite slave port.

module wdtu_top (
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  input  wire logic [11:0] AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [11:0] ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic             RST_REQ,
  output logic             IRQ
);

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  logic                wr_en;
  wdtu_pkg::wdtu_wr_t  wr;
  logic                wr_ok;
  logic                rd_en;
  logic [11:0]         rd_addr;
  wdtu_pkg::wdtu_rd_t  rd;

  wdtu_axil u_axil (
    .clk     (REF_CLK),
    .rst     (SYS_RST),
    .awaddr  (AWADDR),
    .awvalid (AWVALID),
    .awready (AWREADY),
    .wdata   (WDATA),
    .wstrb   (WSTRB),
    .wvalid  (WVALID),
    .wready  (WREADY),
    .bresp   (BRESP),
    .bvalid  (BVALID),
    .bready  (BREADY),
    .araddr  (ARADDR),
    .arvalid (ARVALID),
    .arready (ARREADY),
    .rdata   (RDATA),
    .rresp   (RRESP),
    .rvalid  (RVALID),
    .rready  (RREADY),
    .wr_en   (wr_en),
    .wr      (wr),
    .wr_ok   (wr_ok),
    .rd_en   (rd_en),
    .rd_addr (rd_addr),
    .rd      (rd)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [20:0] limit_of(input logic [2:0] intv);
    logic [4:0] sh;
    sh = 5'(wdtu_pkg::INTV_SHIFT) + {1'b0, intv, 1'b0};
    return 21'h00_0001 << sh;
  endfunction : limit_of

  function automatic logic is_reg(input logic [11:0] a);
    return (a == wdtu_pkg::WDTC_ADDR) || (a == wdtu_pkg::ISTAT_ADDR) ||
           (a == wdtu_pkg::IMASK_ADDR);
  endfunction : is_reg

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic                       enabled;
  logic                       locked;
  logic [2:0]                 interval;
  logic [20:0]                cnt;
  logic                       de_pend;
  logic [2:0]                 de_age;
  logic [wdtu_pkg::EV_W-1:0]  ev_stat;
  logic [wdtu_pkg::EV_W-1:0]  ev_mask;
  logic [wdtu_pkg::EV_W-1:0]  ev_set;
  logic [wdtu_pkg::EV_W-1:0]  next_ev_stat;

  logic       ctl_wr;
  logic [7:0] cbyte;
  logic       is_cmd;
  logic       k_en;
  logic       k_dis1;
  logic       k_dis2;
  logic       k_lock;
  logic       k_other;
  logic       do_disable;
  logic       expire;

  // Only byte lane 0 carries the control byte; a write without it is ignored
  assign ctl_wr  = wr_en && (wr.addr == wdtu_pkg::WDTC_ADDR) && wr.strb[0];
  assign cbyte   = wr.data[7:0];
  assign is_cmd  = cbyte[wdtu_pkg::CMD_BIT];
  assign k_en    = ctl_wr && (cbyte == wdtu_pkg::KEY_ENABLE);
  assign k_dis1  = ctl_wr && (cbyte == wdtu_pkg::KEY_DIS1);
  assign k_dis2  = ctl_wr && (cbyte == wdtu_pkg::KEY_DIS2);
  assign k_lock  = ctl_wr && (cbyte == wdtu_pkg::KEY_LOCK);
  assign k_other = ctl_wr && is_cmd && !k_en && !k_dis1 && !k_dis2 && !k_lock;
  assign do_disable = k_dis2 && de_pend && !locked;
  assign expire     = enabled && (cnt >= limit_of(interval));
  assign wr_ok      = is_reg(wr.addr);

  // ----------------------------------------------------------------
  // Enable and lockout
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      enabled <= 1'b1;
    end else if (k_en) begin
      enabled <= 1'b1;
    end else if (do_disable) begin
      enabled <= 1'b0;
    end
  end

  // The lock key sets this flag and the lock event, and drops a half-done disable sequence
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      locked <= 1'b0;
    end else if (k_lock) begin
      locked <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Disable sequence window
  // ----------------------------------------------------------------
  // Any other command write (bit 7 set) drops a half-done sequence, so a stray key cannot
  // pair with a later second key; an interval write leaves it pending
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      de_pend <= 1'b0;
      de_age  <= 3'h0;
    end else if (k_dis1) begin
      de_pend <= 1'b1;
      de_age  <= 3'h1;
    end else if (k_dis2 || k_other || k_en || k_lock) begin
      de_pend <= 1'b0;
      de_age  <= 3'h0;
    end else if (de_pend) begin
      if (de_age >= wdtu_pkg::DIS_WIN_CYC) begin
        de_pend <= 1'b0;
        de_age  <= 3'h0;
      end else begin
        de_age <= de_age + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interval field
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      interval <= wdtu_pkg::INTV_RST;
    end else if (ctl_wr && !is_cmd) begin
      interval <= cbyte[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Timeout counter
  // ----------------------------------------------------------------
  // Expiry restarts the count as well, so the unit stays sane even when the
  // reset request is not looped back to SYS_RST
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      cnt <= 21'h00_0000;
    end else if (!enabled || k_en || expire) begin
      cnt <= 21'h00_0000;
    end else begin
      cnt <= cnt + 21'h00_0001;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      RST_REQ <= 1'b0;
    end else begin
      RST_REQ <= expire;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  always_comb begin
    ev_set                        = '0;
    ev_set[wdtu_pkg::EV_EXPIRE]   = expire;
    ev_set[wdtu_pkg::EV_DISABLE]  = do_disable;
    ev_set[wdtu_pkg::EV_LOCK]     = k_lock;
    ev_set[wdtu_pkg::EV_REJECT]   = k_dis2 && !do_disable;
    next_ev_stat = ev_stat;
    if (rd_en && (rd_addr == wdtu_pkg::ISTAT_ADDR)) begin
      next_ev_stat = '0;
    end
    // A set in the clearing cycle survives
    next_ev_stat = next_ev_stat | ev_set;
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ev_stat <= '0;
    end else begin
      ev_stat <= next_ev_stat;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ev_mask <= '0;
    end else if (wr_en && (wr.addr == wdtu_pkg::IMASK_ADDR) && wr.strb[0]) begin
      ev_mask <= wr.data[wdtu_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(next_ev_stat & ev_mask);
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd.data = 32'h0000_0000;
    rd.ok   = 1'b1;
    unique case (rd_addr)
      wdtu_pkg::WDTC_ADDR: begin
        rd.data[2:0]                = interval;
        rd.data[wdtu_pkg::STAT_BIT] = enabled;
      end
      wdtu_pkg::ISTAT_ADDR: begin
        rd.data[wdtu_pkg::EV_W-1:0] = ev_stat;
      end
      wdtu_pkg::IMASK_ADDR: begin
        rd.data[wdtu_pkg::EV_W-1:0] = ev_mask;
      end
      default: begin
        rd.ok = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  count_step_a: assert property (
    enabled && !k_en && !expire |=> cnt == $past(cnt) + 21'h00_0001)
    else $error("counter did not advance");

  expire_req_a: assert property (
    enabled && (cnt == limit_of(interval)) |=> RST_REQ && (cnt == 21'h00_0000))
    else $error("no reset request at timeout");

  no_early_a: assert property (
    RST_REQ |-> $past(cnt) >= limit_of($past(interval)))
    else $error("reset request before timeout");

  enable_key_a: assert property (
    k_en |=> enabled && (cnt == 21'h00_0000))
    else $error("enable key did not enable and restart");

  after_reset_a: assert property (
    $past(SYS_RST) |-> enabled && !locked && (cnt == 21'h00_0000) &&
                       (interval == wdtu_pkg::INTV_RST))
    else $error("bad state after reset");

  disable_seq_a: assert property (
    (!k_en && !k_lock && !k_other) throughout (k_dis1 && !locked ##[1:4] k_dis2) |=> !enabled)
    else $error("timely disable sequence ignored");

  only_key_a: assert property (
    $fell(enabled) |-> $past(k_dis2) && $past(de_pend))
    else $error("disabled without a sequence");

  late_key_a: assert property (
    k_dis1 ##1 (!ctl_wr) [*4] ##1 k_dis2 |=> enabled == $past(enabled))
    else $error("late second key accepted");

  lock_hold_a: assert property (
    locked |=> locked && (!$past(do_disable)))
    else $error("lockout lost or bypassed");

  lock_key_a: assert property (
    k_lock && enabled && !expire |=> enabled && (cnt == $past(cnt) + 21'h00_0001))
    else $error("lock key touched the countdown");

  interval_wr_a: assert property (
    ctl_wr && !is_cmd |=> interval == $past(cbyte[2:0]))
    else $error("interval field not updated");

  ctl_read_a: assert property (
    rd_en && (rd_addr == wdtu_pkg::WDTC_ADDR) |=>
      RDATA[7:0] == {3'h0, $past(enabled), 1'b0, $past(interval)})
    else $error("control read value wrong");

  key_cancel_a: assert property (
    k_other |=> !de_pend && (enabled == $past(enabled)))
    else $error("stray key did not cancel");

  expire_c:  cover property (expire ##1 RST_REQ);
  disable_c: cover property (k_dis1 ##[1:4] k_dis2 ##1 !enabled);
  locked_c:  cover property (locked && k_dis2);
  irq_c:     cover property ($rose(IRQ));

endmodule : wdtu_top

// file: testbench/tb_top.sv
// Self-checking testbench of the watchdog timer unit over AXI4-Lite
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL    = wdtu_pkg::WDTC_ADDR;
  localparam logic [11:0] STAT    = wdtu_pkg::ISTAT_ADDR;
  localparam logic [11:0] MASK    = wdtu_pkg::IMASK_ADDR;
  localparam int          TIMEOUT = 6000;   // Whole sequence needs well under a thousand cycles
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [11:0] awaddr  = 12'h000;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata   = 32'h00000000;
  logic [3:0]  wstrb   = 4'h0;
  logic        wvalid  = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready  = 1'b0;
  logic [11:0] araddr  = 12'h000;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready  = 1'b0;
  logic        rst_req;
  logic        irq;
  logic [31:0] rnd     = 32'h0000_E254;
  logic [33:0] exp_rd[$];
  logic [1:0]  exp_b[$];
  int          exp_rst[$];
  int          cyc     = 0;
  int          last_act;
  int          t;
  int          error_cnt = 0;
  int          check_count = 0;

  always #20 ref_clk = ~ref_clk;

  wdtu_top i_wdtu_top (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .RST_REQ(rst_req), .IRQ(irq)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xorshift

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h, expected %h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic note(input string name);
    $display("test %s done", name);
  endtask : note

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle

  task automatic wait_until(input int c);
    while (cyc < c) @(negedge ref_clk);
  endtask : wait_until

  task automatic irq_is(input logic b);
    @(negedge ref_clk);
    check({33'h0, irq}, {33'h0, b});
  endtask : irq_is

  // Upper data bits and strobes are random: only byte 0 may matter
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic aw_ok;
    logic w_ok;
    logic aw_go;
    logic w_go;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    rnd = xorshift(rnd);
    exp_b.push_back((a == CTRL || a == STAT || a == MASK) ? wdtu_pkg::RESP_OKAY :
                    wdtu_pkg::RESP_SLVERR);
    @(posedge ref_clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {rnd[31:8], d};
    wstrb <= {rnd[3:1], 1'b1};
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge ref_clk);
      aw_go = !aw_ok && awready === 1'b1;
      w_go = !w_ok && wready === 1'b1;
      last_act = cyc + 1;
      @(posedge ref_clk);
      if (aw_go) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (w_go) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
    end
    @(negedge ref_clk);
    while (bvalid !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [33:0] exp);
    exp_rd.push_back(exp);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(negedge ref_clk);
    while (arready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    arvalid <= 1'b0;
    @(negedge ref_clk);
    while (rvalid !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [7:0] v);
    rd(CTRL, {26'h0, v});
  endtask : rc

  task automatic rs(input logic [7:0] v);
    rd(STAT, {26'h0, v});
  endtask : rs

  // ----------------------------------------------------------------
  // Watcher and timeout
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc >= TIMEOUT) begin
      error_cnt++;
      complete_run();
    end
  end

  // A result with no pending note compares against an impossible value
  always @(negedge ref_clk) begin
    if (bvalid === 1'b1 && bready === 1'b1) begin
      check({32'h0, bresp}, (exp_b.size() == 0) ? 34'h3FFFFFFFF : {32'h0, exp_b.pop_front()});
    end
    if (rvalid === 1'b1 && rready === 1'b1) begin
      check({rresp, rdata}, (exp_rd.size() == 0) ? 34'h3FFFFFFFF : exp_rd.pop_front());
    end
    if (rst_req !== 1'b0) begin
      check(34'(cyc), (exp_rst.size() == 0) ? 34'h3FFFFFFFF : 34'(exp_rst.pop_front()));
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    idle(20);
    sys_rst <= 1'b0;
    rc(8'h17);
    rs(8'h00);
    rd(12'h800, {wdtu_pkg::RESP_SLVERR, 32'h0});
    wr(12'h800, 8'h5A);
    note("reset values");
    wr(MASK, 8'h0F);
    wr(CTRL, 8'h05);
    rc(8'h15);
    wr(CTRL, 8'h00);
    rc(8'h10);
    note("interval");
    wr(CTRL, wdtu_pkg::KEY_ENABLE);
    t = last_act;
    exp_rst.push_back(t + 65);
    wait_until(t + 67);
    irq_is(1'b1);
    rs(8'h01);
    rs(8'h00);
    idle(2);
    irq_is(1'b0);
    note("expiry");
    wr(CTRL, wdtu_pkg::KEY_ENABLE);
    wr(CTRL, wdtu_pkg::KEY_DIS1);
    // Second key lands five edges after the first: just outside the window
    idle(2);
    wr(CTRL, wdtu_pkg::KEY_DIS2);
    rc(8'h10);
    rs(8'h08);
    wr(CTRL, wdtu_pkg::KEY_DIS1);
    wr(CTRL, 8'h83);
    wr(CTRL, wdtu_pkg::KEY_DIS2);
    rc(8'h10);
    rs(8'h08);
    note("refused disable");
    wr(CTRL, wdtu_pkg::KEY_ENABLE);
    wr(CTRL, wdtu_pkg::KEY_DIS1);
    wr(CTRL, wdtu_pkg::KEY_DIS2);
    rc(8'h00);
    rs(8'h02);
    note("disable");
    wr(MASK, 8'h0B);
    wr(CTRL, wdtu_pkg::KEY_LOCK);
    rc(8'h00);
    idle(100);
    irq_is(1'b0);
    rs(8'h04);
    note("lock while disabled");
    // Lock key mid-interval must not move the expiry point
    wr(CTRL, wdtu_pkg::KEY_ENABLE);
    t = last_act;
    exp_rst.push_back(t + 65);
    idle(10);
    wr(CTRL, wdtu_pkg::KEY_LOCK);
    wr(CTRL, wdtu_pkg::KEY_DIS1);
    wr(CTRL, wdtu_pkg::KEY_DIS2);
    rc(8'h10);
    wait_until(t + 70);
    rs(8'h0D);
    note("locked");
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    idle(20);
    sys_rst <= 1'b0;
    rc(8'h17);
    wr(CTRL, wdtu_pkg::KEY_DIS1);
    // Second key lands four edges after the first: last edge inside the window
    idle(1);
    wr(CTRL, wdtu_pkg::KEY_DIS2);
    rc(8'h07);
    note("second reset");
    complete_run();
  end

endmodule : tb_top
